// *** design/pcs_pkg.sv ***
// Purpose: Constants shared by the configuration status block.
// Assumes: 50 MHz CLK, APB slave with 32-bit data, byte offsets.
// Notes: Training state codes follow the fixed hexadecimal ordering.
//
// Overview of operation
// - Link-down output is 1 while LinkUp is 0, and 0 while LinkUp is 1.
// - Link-down output reads 0 during reset; real state only after release.
// - LinkUp is 1 in Recovery, L0, L0s, L1 and L2.
// - In Configuration LinkUp keeps 0 after Polling, 1 after Recovery or an active state.
// - Link status: 00 no receivers, 01 training, 10 DL init, 11 DL done.
// - Width output mirrors Link Status width; valid only while status is 11.
// - Speed output from Link Status bits 1:0 as 001, 010 or 100; code 00 reads 000.
// - Payload-limit output mirrors Device Control bits 7:5, 128 to 4096 bytes.
// - Read-request-limit output mirrors Device Control bits 14:12.
// - Function status: four Command bits per physical function, PF1 high.
// - VF status: per VF, low bit enabled, high bit bus master enable.
// - PF power state three bits each: 000, 001 D0 active, 010 D1, 100 D3hot.
// - Training state shown as hex code, 00 Detect.Quiet onward.
package pcs_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFS_DEV_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD_PF0 = 8'h04;
  localparam logic [7:0] OFS_CMD_PF1 = 8'h08;
  localparam logic [7:0] OFS_VF_CTRL = 8'h0c;
  localparam logic [7:0] OFS_PM_CTRL = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // Values after reset.
  localparam logic [15:0] DEV_CTRL_RST = 16'h2000;
  localparam logic [15:0] CMD_RST = 16'h0000;
  localparam logic [11:0] VF_CTRL_RST = 12'h000;
  localparam logic [3:0] PM_CTRL_RST = 4'h0;

  // Field positions.
  localparam int MPS_LSB = 5;
  localparam int MRRS_LSB = 12;
  localparam int CMD_IO = 0;
  localparam int CMD_MEM = 1;
  localparam int CMD_BME = 2;
  localparam int CMD_INTX = 10;
  localparam int VF_BME_LSB = 6;
  localparam int LS_WIDTH_LSB = 4;
  localparam int ST_LINK_STAT_LSB = 6;
  localparam int ST_LINK_DOWN = 8;
  localparam int ST_WIDTH_LSB = 9;
  localparam int ST_SPEED_LSB = 13;

  // Counts.
  localparam int NUM_PF = 2;
  localparam int NUM_VF = 6;

  // Power state codes as software writes them.
  localparam logic [1:0] PMCSR_D0 = 2'h0;
  localparam logic [1:0] PMCSR_D1 = 2'h1;
  localparam logic [1:0] PMCSR_D2 = 2'h2;
  localparam logic [1:0] PMCSR_D3 = 2'h3;

  // Reported power state codes.
  localparam logic [2:0] PWR_D0_UNINIT = 3'h0;
  localparam logic [2:0] PWR_D0_ACTIVE = 3'h1;
  localparam logic [2:0] PWR_D1 = 3'h2;
  localparam logic [2:0] PWR_D3_HOT = 3'h4;

  // Speed codes.
  localparam logic [1:0] LS_SPEED_2G5 = 2'h1;
  localparam logic [1:0] LS_SPEED_5G = 2'h2;
  localparam logic [1:0] LS_SPEED_8G = 2'h3;
  localparam logic [2:0] SPD_2G5 = 3'h1;
  localparam logic [2:0] SPD_5G = 3'h2;
  localparam logic [2:0] SPD_8G = 3'h4;
  localparam logic [2:0] SPD_NONE = 3'h0;

  // Link status codes.
  localparam logic [1:0] LST_NO_RX = 2'h0;
  localparam logic [1:0] LST_TRAIN = 2'h1;
  localparam logic [1:0] LST_DL_INIT = 2'h2;
  localparam logic [1:0] LST_DL_DONE = 2'h3;

  // Training state codes.
  localparam logic [5:0] LT_DETECT_QUIET = 6'h00;
  localparam logic [5:0] LT_DETECT_ACTIVE = 6'h01;
  localparam logic [5:0] LT_POLL_FIRST = 6'h02;
  localparam logic [5:0] LT_POLL_LAST = 6'h04;
  localparam logic [5:0] LT_CFG_FIRST = 6'h05;
  localparam logic [5:0] LT_CFG_LAST = 6'h0a;
  localparam logic [5:0] LT_RCV_FIRST = 6'h0b;
  localparam logic [5:0] LT_RCV_LAST = 6'h0d;
  localparam logic [5:0] LT_L0 = 6'h10;
  localparam logic [5:0] LT_L0S = 6'h11;
  localparam logic [5:0] LT_L1 = 6'h12;
  localparam logic [5:0] LT_L2 = 6'h13;
endpackage

// *** design/pcs_link_track.sv ***
// Purpose: Derives LinkUp and the two-bit link status from training state.
// Assumes: Training state code and DL-up flag are synchronous to CLK.
// Notes: Outputs are registered one cycle after the inputs.
`timescale 1ns/1ps
module pcs_link_track (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Link state in.
  input wire logic [5:0] ltssm,
  input wire logic dl_up,
  // Derived state out.
  output logic link_up_r,
  output logic [1:0] link_stat_r
);
  logic is_detect;
  logic is_cfg;
  logic is_active;
  logic link_up_nxt;
  logic [1:0] link_stat_nxt;

  always_comb begin
    is_detect = (ltssm == pcs_pkg::LT_DETECT_QUIET) ||
                (ltssm == pcs_pkg::LT_DETECT_ACTIVE);
    is_cfg = (ltssm >= pcs_pkg::LT_CFG_FIRST) &&
             (ltssm <= pcs_pkg::LT_CFG_LAST);
    is_active = ((ltssm >= pcs_pkg::LT_RCV_FIRST) &&
                 (ltssm <= pcs_pkg::LT_RCV_LAST)) ||
                (ltssm == pcs_pkg::LT_L0) || (ltssm == pcs_pkg::LT_L0S) ||
                (ltssm == pcs_pkg::LT_L1) || (ltssm == pcs_pkg::LT_L2);
  end

  // Configuration keeps the value it was entered with: 0 after Polling,
  // 1 after Recovery or an active state.
  always_comb begin
    if (is_active) begin
      link_up_nxt = 1'b1;
    end else if (is_cfg) begin
      link_up_nxt = link_up_r;
    end else begin
      link_up_nxt = 1'b0;
    end
  end

  always_comb begin
    if (is_detect) begin
      link_stat_nxt = pcs_pkg::LST_NO_RX;
    end else if (!link_up_nxt) begin
      link_stat_nxt = pcs_pkg::LST_TRAIN;
    end else if (!dl_up) begin
      link_stat_nxt = pcs_pkg::LST_DL_INIT;
    end else begin
      link_stat_nxt = pcs_pkg::LST_DL_DONE;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      link_up_r <= 1'b0;
      link_stat_r <= pcs_pkg::LST_NO_RX;
    end else begin
      link_up_r <= link_up_nxt;
      link_stat_r <= link_stat_nxt;
    end
  end
endmodule

// *** design/pcs_status_top.sv ***
// Purpose: Configuration status outputs with an APB register file.
// Assumes: Training state, DL-up and Link Status inputs synchronous to CLK.
// Notes: Every status output is a flop, one cycle behind its source; link-down and link status are two cycles behind the inputs.
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ps
module pcs_status_top (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RST,
  // APB slave.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Physical layer inputs.
  input wire logic [5:0] LTSSM_STATE,
  input wire logic DL_UP,
  input wire logic [15:0] LINK_STAT_IN,
  // Status outputs.
  output logic PHY_LINK_DOWN,
  output logic [1:0] PHY_LINK_STATUS,
  output logic [3:0] NEGOTIATED_WIDTH,
  output logic [2:0] CURRENT_SPEED,
  output logic [2:0] MAX_PAYLOAD,
  output logic [2:0] MAX_READ_REQ,
  output logic [7:0] FUNCTION_STATUS,
  output logic [11:0] VF_ENABLE_BITS,
  output logic [5:0] FUNCTION_POWER_STATE,
  output logic [5:0] LTSSM_CODE
);
  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] dev_ctrl_r;
  logic [15:0] cmd_r [pcs_pkg::NUM_PF];
  logic [11:0] vf_ctrl_r;
  logic [3:0] pm_ctrl_r;
  logic link_up;
  logic [1:0] link_stat;
  logic [31:0] status_word;
  logic [31:0] rd_nxt;
  logic hit;
  logic wr_en;
  logic [31:0] wr_merged;
  logic [2:0] speed_nxt;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  pcs_link_track u_track (
    .clk(CLK),
    .rst(RST),
    .ltssm(LTSSM_STATE),
    .dl_up(DL_UP),
    .link_up_r(link_up),
    .link_stat_r(link_stat)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB decode. The slave answers one cycle into the access phase at most.
  always_comb begin
    hit = 1'b1;
    rd_nxt = 32'h0000_0000;
    unique case (PADDR)
      pcs_pkg::OFS_DEV_CTRL: rd_nxt = {16'h0000, dev_ctrl_r};
      pcs_pkg::OFS_CMD_PF0: rd_nxt = {16'h0000, cmd_r[0]};
      pcs_pkg::OFS_CMD_PF1: rd_nxt = {16'h0000, cmd_r[1]};
      pcs_pkg::OFS_VF_CTRL: rd_nxt = {20'h0_0000, vf_ctrl_r};
      pcs_pkg::OFS_PM_CTRL: rd_nxt = {28'h000_0000, pm_ctrl_r};
      pcs_pkg::OFS_STATUS: rd_nxt = status_word;
      default: hit = 1'b0;
    endcase
  end

  assign wr_en = PSEL && PENABLE && PREADY && PWRITE && hit;

  always_comb begin
    wr_merged = merge(rd_nxt, PWDATA, PSTRB);
  end

  // Ready rises for exactly the one access cycle after each setup cycle.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PREADY <= 1'b0;
    end else begin
      PREADY <= PSEL && !PENABLE && !PREADY;
    end
  end

  // Read data is captured in the setup cycle and held until the next one.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PRDATA <= 32'h0000_0000;
    end else if (PSEL && !PENABLE) begin
      PRDATA <= PWRITE ? 32'h0000_0000 : rd_nxt;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PSLVERR <= 1'b0;
    end else if (PSEL && !PENABLE) begin
      PSLVERR <= !hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software-written configuration registers.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      dev_ctrl_r <= pcs_pkg::DEV_CTRL_RST;
    end else if (wr_en && PADDR == pcs_pkg::OFS_DEV_CTRL) begin
      dev_ctrl_r <= wr_merged[15:0];
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cmd_r[0] <= pcs_pkg::CMD_RST;
    end else if (wr_en && PADDR == pcs_pkg::OFS_CMD_PF0) begin
      cmd_r[0] <= wr_merged[15:0];
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cmd_r[1] <= pcs_pkg::CMD_RST;
    end else if (wr_en && PADDR == pcs_pkg::OFS_CMD_PF1) begin
      cmd_r[1] <= wr_merged[15:0];
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      vf_ctrl_r <= pcs_pkg::VF_CTRL_RST;
    end else if (wr_en && PADDR == pcs_pkg::OFS_VF_CTRL) begin
      vf_ctrl_r <= wr_merged[11:0];
    end
  end

  // Writes requesting D2 are not supported and leave that field unchanged.
  genvar p;
  generate
    for (p = 0; p < pcs_pkg::NUM_PF; p++) begin : g_pm
      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          pm_ctrl_r[p*2 +: 2] <= pcs_pkg::PM_CTRL_RST[p*2 +: 2];
        end else if (wr_en && PADDR == pcs_pkg::OFS_PM_CTRL &&
                     wr_merged[p*2 +: 2] != pcs_pkg::PMCSR_D2) begin
          pm_ctrl_r[p*2 +: 2] <= wr_merged[p*2 +: 2];
        end
      end

      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          FUNCTION_STATUS[p*4 +: 4] <= 4'h0;
        end else begin
          FUNCTION_STATUS[p*4 +: 4] <= {cmd_r[p][pcs_pkg::CMD_INTX],
                                        cmd_r[p][pcs_pkg::CMD_BME],
                                        cmd_r[p][pcs_pkg::CMD_MEM],
                                        cmd_r[p][pcs_pkg::CMD_IO]};
        end
      end

      // D0 reads as active only once software has enabled a decode space.
      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          FUNCTION_POWER_STATE[p*3 +: 3] <= pcs_pkg::PWR_D0_UNINIT;
        end else begin
          unique case (pm_ctrl_r[p*2 +: 2])
            pcs_pkg::PMCSR_D0: begin
              FUNCTION_POWER_STATE[p*3 +: 3] <=
                (cmd_r[p][pcs_pkg::CMD_IO] || cmd_r[p][pcs_pkg::CMD_MEM]) ?
                pcs_pkg::PWR_D0_ACTIVE : pcs_pkg::PWR_D0_UNINIT;
            end
            pcs_pkg::PMCSR_D1: begin
              FUNCTION_POWER_STATE[p*3 +: 3] <= pcs_pkg::PWR_D1;
            end
            pcs_pkg::PMCSR_D3: begin
              FUNCTION_POWER_STATE[p*3 +: 3] <= pcs_pkg::PWR_D3_HOT;
            end
            default: begin
              FUNCTION_POWER_STATE[p*3 +: 3] <= pcs_pkg::PWR_D0_UNINIT;
            end
          endcase
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Virtual function status pairs.
  genvar v;
  generate
    for (v = 0; v < pcs_pkg::NUM_VF; v++) begin : g_vf
      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          VF_ENABLE_BITS[v*2 +: 2] <= 2'h0;
        end else begin
          VF_ENABLE_BITS[v*2 +: 2] <=
            {vf_ctrl_r[pcs_pkg::VF_BME_LSB + v], vf_ctrl_r[v]};
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Link state outputs.
  always_comb begin
    unique case (LINK_STAT_IN[1:0])
      pcs_pkg::LS_SPEED_2G5: speed_nxt = pcs_pkg::SPD_2G5;
      pcs_pkg::LS_SPEED_5G: speed_nxt = pcs_pkg::SPD_5G;
      pcs_pkg::LS_SPEED_8G: speed_nxt = pcs_pkg::SPD_8G;
      default: speed_nxt = pcs_pkg::SPD_NONE;
    endcase
  end

  // Link-down is 0 in reset, then follows LinkUp inverted.
  // These sit one flop behind the tracker, two cycles behind the inputs.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PHY_LINK_DOWN <= 1'b0;
    end else begin
      PHY_LINK_DOWN <= !link_up;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PHY_LINK_STATUS <= pcs_pkg::LST_NO_RX;
    end else begin
      PHY_LINK_STATUS <= link_stat;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      LTSSM_CODE <= pcs_pkg::LT_DETECT_QUIET;
    end else begin
      LTSSM_CODE <= LTSSM_STATE;
    end
  end

  // Width is only meaningful to the user while link status reads 11.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      NEGOTIATED_WIDTH <= 4'h0;
    end else begin
      NEGOTIATED_WIDTH <= LINK_STAT_IN[pcs_pkg::LS_WIDTH_LSB +: 4];
    end
  end

  // An unknown speed field reads as zero rather than a false speed.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      CURRENT_SPEED <= pcs_pkg::SPD_NONE;
    end else begin
      CURRENT_SPEED <= speed_nxt;
    end
  end

  // Limits the user logic must respect on transmit and read requests.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      MAX_PAYLOAD <= pcs_pkg::DEV_CTRL_RST[pcs_pkg::MPS_LSB +: 3];
    end else begin
      MAX_PAYLOAD <= dev_ctrl_r[pcs_pkg::MPS_LSB +: 3];
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      MAX_READ_REQ <= pcs_pkg::DEV_CTRL_RST[pcs_pkg::MRRS_LSB +: 3];
    end else begin
      MAX_READ_REQ <= dev_ctrl_r[pcs_pkg::MRRS_LSB +: 3];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read-only status word.
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[5:0] = LTSSM_CODE;
    status_word[pcs_pkg::ST_LINK_STAT_LSB +: 2] = PHY_LINK_STATUS;
    status_word[pcs_pkg::ST_LINK_DOWN] = PHY_LINK_DOWN;
    status_word[pcs_pkg::ST_WIDTH_LSB +: 4] = NEGOTIATED_WIDTH;
    status_word[pcs_pkg::ST_SPEED_LSB +: 3] = CURRENT_SPEED;
  end
endmodule

// *** testbench/pcs_status_top_props.sv ***
// Purpose: Assertions on the status outputs and APB answers.
// Assumes: Single clock, asynchronous active-high reset.
// Notes: Link checks wait a few cycles after reset for the pipeline.
`timescale 1ns/1ps
module pcs_status_props (
  // Clock, reset and APB.
  input wire logic CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  // Link inputs.
  input wire logic [5:0] LTSSM_STATE,
  input wire logic DL_UP,
  input wire logic [15:0] LINK_STAT_IN,
  // Status outputs.
  input wire logic PHY_LINK_DOWN,
  input wire logic [1:0] PHY_LINK_STATUS,
  input wire logic [3:0] NEGOTIATED_WIDTH,
  input wire logic [2:0] CURRENT_SPEED, MAX_PAYLOAD, MAX_READ_REQ,
  input wire logic [5:0] LTSSM_CODE
);
  logic [11:0] src_r;
  logic [1:0] age_r;
  logic up, ok, dev_wr;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  assign up = LTSSM_STATE inside {[6'h0b:6'h0d], [6'h10:6'h13]};
  assign ok = age_r == 2'h3;
  assign dev_wr = PSEL && PENABLE && PREADY && PWRITE && PADDR == 8'h00;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) src_r <= '0;
    else src_r <= {LTSSM_STATE, LINK_STAT_IN[7:4], LINK_STAT_IN[1:0]};
  end
  // Counts cycles since reset so link checks skip the pipeline fill.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) age_r <= '0;
    else if (!ok) age_r <= age_r + 2'h1;
  end
  a_code_copy: assert property (LTSSM_CODE == src_r[11:6])
    else $error("training code not copied");
  a_speed_map: assert property (
    CURRENT_SPEED == {src_r[1:0] == 2'h3, src_r[1:0] == 2'h2,
                      src_r[1:0] == 2'h1})
    else $error("speed code wrong");
  a_width_copy: assert property (NEGOTIATED_WIDTH == src_r[5:2])
    else $error("width not copied");
  a_up_clear: assert property (ok && up |-> ##2 !PHY_LINK_DOWN)
    else $error("link down while up state");
  a_train_down: assert property (
    ok && LTSSM_STATE <= 6'h04 |-> ##2 PHY_LINK_DOWN)
    else $error("link up in detect or polling");
  a_status_done: assert property (
    (ok && up && DL_UP)[*2] |-> ##1 PHY_LINK_STATUS == 2'h3)
    else $error("status not 11 when up");
  a_status_idle: assert property (
    (ok && LTSSM_STATE < 6'h02)[*2] |-> ##1 PHY_LINK_STATUS == 2'h0)
    else $error("status not 00 in detect");
  a_reset_vals: assert property (disable iff (1'b0)
    RST |-> !PHY_LINK_DOWN && MAX_READ_REQ == 3'h2)
    else $error("reset values wrong");
  a_mps_follow: assert property (
    dev_wr && PSTRB[0] |-> ##2 MAX_PAYLOAD == $past(PWDATA[7:5], 2))
    else $error("payload limit not updated");
  a_mrrs_follow: assert property (
    dev_wr && PSTRB[1] |-> ##2 MAX_READ_REQ == $past(PWDATA[14:12], 2))
    else $error("read limit not updated");
  a_ready_pulse: assert property (
    PSEL && !PENABLE |=> PREADY ##1 !PREADY)
    else $error("ready not one cycle");
  a_err_unmap: assert property (PREADY && PADDR > 8'h14 |-> PSLVERR)
    else $error("unmapped access without error");
  c_link_up: cover property (up && DL_UP && ok);
  c_error: cover property (PREADY && PSLVERR);
  c_dev_write: cover property (dev_wr);
endmodule
bind pcs_status_top pcs_status_props props_u (
  .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .PADDR(PADDR), .PWDATA(PWDATA),
  .PSTRB(PSTRB), .LTSSM_STATE(LTSSM_STATE), .DL_UP(DL_UP),
  .LINK_STAT_IN(LINK_STAT_IN), .PHY_LINK_DOWN(PHY_LINK_DOWN),
  .PHY_LINK_STATUS(PHY_LINK_STATUS), .NEGOTIATED_WIDTH(NEGOTIATED_WIDTH),
  .CURRENT_SPEED(CURRENT_SPEED), .MAX_PAYLOAD(MAX_PAYLOAD),
  .MAX_READ_REQ(MAX_READ_REQ), .LTSSM_CODE(LTSSM_CODE));

// *** testbench/pcs_user_model.sv ***
// Purpose: User-side consumer of the status outputs.
// Assumes: Limits are used as byte counts by transmit and read logic.
// Notes: Width is only used while the link is fully up.
`timescale 1ns/1ps
module pcs_user_model (
  // Clock.
  input wire logic clk,
  // Status seen from the core.
  input wire logic [1:0] link_status,
  input wire logic [3:0] width,
  input wire logic [2:0] mps,
  input wire logic [2:0] mrrs,
  // Limits the user logic obeys.
  output logic [12:0] pay_limit,
  output logic [12:0] rd_limit,
  output logic [3:0] lanes
);
  always_ff @(posedge clk) begin
    pay_limit <= 13'h0080 << mps;
    rd_limit <= 13'h0080 << mrrs;
    lanes <= (link_status == 2'h3) ? width : 4'h0;
  end
endmodule

// *** testbench/pcie_config_status_outputs_tb.sv ***
// Purpose: Self-checking bench for the configuration status block.
// Assumes: APB answer after one access cycle, registered outputs.
// Notes: Link states walk detect, training, up and re-entry paths.
`timescale 1ns/1ps
module pcie_config_status_outputs_tb;
  logic CLK = 0, RST = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, DL_UP = 0;
  logic [7:0] PADDR = '0;
  logic [31:0] PWDATA = '0, PRDATA, rd;
  logic [3:0] PSTRB = '0, NEGOTIATED_WIDTH, lanes;
  logic [5:0] LTSSM_STATE = '0, FUNCTION_POWER_STATE, LTSSM_CODE;
  logic [15:0] LINK_STAT_IN = '0;
  logic PREADY, PSLVERR, PHY_LINK_DOWN, er;
  logic [1:0] PHY_LINK_STATUS;
  logic [2:0] CURRENT_SPEED, MAX_PAYLOAD, MAX_READ_REQ;
  logic [7:0] FUNCTION_STATUS;
  logic [11:0] VF_ENABLE_BITS;
  logic [12:0] pay_limit, rd_limit;
  int n_mismatch = 0, n_compared = 0;
  logic [5:0] st [10] = '{6'h00, 6'h02, 6'h05, 6'h3f, 6'h10, 6'h10,
                          6'h0b, 6'h05, 6'h11, 6'h13};
  logic [9:0] dl = 10'h3e0, dn = 10'h00f;
  logic [1:0] ls [10] = '{2'h0, 2'h1, 2'h1, 2'h1, 2'h2, 2'h3, 2'h3,
                          2'h3, 2'h3, 2'h3};
  pcs_status_top dut_u (
    .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .LTSSM_STATE(LTSSM_STATE),
    .DL_UP(DL_UP), .LINK_STAT_IN(LINK_STAT_IN),
    .PHY_LINK_DOWN(PHY_LINK_DOWN), .PHY_LINK_STATUS(PHY_LINK_STATUS),
    .NEGOTIATED_WIDTH(NEGOTIATED_WIDTH), .CURRENT_SPEED(CURRENT_SPEED),
    .MAX_PAYLOAD(MAX_PAYLOAD), .MAX_READ_REQ(MAX_READ_REQ),
    .FUNCTION_STATUS(FUNCTION_STATUS), .VF_ENABLE_BITS(VF_ENABLE_BITS),
    .FUNCTION_POWER_STATE(FUNCTION_POWER_STATE), .LTSSM_CODE(LTSSM_CODE));
  pcs_user_model user_u (.clk(CLK), .link_status(PHY_LINK_STATUS),
    .width(NEGOTIATED_WIDTH), .mps(MAX_PAYLOAD), .mrrs(MAX_READ_REQ),
    .pay_limit(pay_limit), .rd_limit(rd_limit), .lanes(lanes));
  initial forever #10 CLK = ~CLK;
  task automatic tick(int n);
    repeat (n) @(posedge CLK);
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer; leaves one idle cycle so strobes never double-drive.
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic [3:0] s);
    int n;
    n = 0;
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    PSTRB <= s;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    if (n >= 50) n_mismatch++;
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic stop_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #(20 * 3000);
    n_mismatch++;
    stop_test();
  end
  initial begin
    RST <= 1'b1;
    tick(3);
    chk("down_rst", 0, PHY_LINK_DOWN);
    chk("mrrs_rst", 3'h2, MAX_READ_REQ);
    tick(3);
    RST <= 1'b0;
    tick(1);
    apb(0, pcs_pkg::OFS_DEV_CTRL, 0, 4'hf);
    chk("devctl_rst", 32'h2000, rd);
    chk("down_rel", 1, PHY_LINK_DOWN);
    $display("test reset done");
    for (int i = 0; i < 10; i++) begin
      LTSSM_STATE <= st[i];
      DL_UP <= dl[i];
      tick(3);
      chk("down", dn[i], PHY_LINK_DOWN);
      chk("lstat", ls[i], PHY_LINK_STATUS);
      chk("code", st[i], LTSSM_CODE);
    end
    for (int i = 0; i < 4; i++) begin
      LINK_STAT_IN <= {8'h00, 4'h8, 2'h0, 2'(i)};
      tick(3);
      chk("speed", i == 0 ? 0 : 1 << (i - 1), CURRENT_SPEED);
      chk("width", 4'h8, NEGOTIATED_WIDTH);
      chk("lanes", 4'h8, lanes);
    end
    $display("test link done");
    apb(1, pcs_pkg::OFS_DEV_CTRL, 32'h50a0, 4'hf);
    tick(3);
    chk("mps", 3'h5, MAX_PAYLOAD);
    chk("mrrs", 3'h5, MAX_READ_REQ);
    chk("pay", 13'h1000, pay_limit);
    chk("rdlim", 13'h1000, rd_limit);
    apb(1, pcs_pkg::OFS_DEV_CTRL, 32'h0020, 4'h1);
    tick(3);
    chk("mps", 3'h1, MAX_PAYLOAD);
    chk("mrrs", 3'h5, MAX_READ_REQ);
    apb(1, pcs_pkg::OFS_CMD_PF0, 32'h0407, 4'h3);
    apb(1, pcs_pkg::OFS_CMD_PF1, 32'h0004, 4'h3);
    apb(1, pcs_pkg::OFS_VF_CTRL, 32'h00c1, 4'h3);
    tick(3);
    chk("fstat", 8'h4f, FUNCTION_STATUS);
    chk("vf", 12'h00b, VF_ENABLE_BITS);
    chk("pwr", 6'h01, FUNCTION_POWER_STATE);
    apb(1, pcs_pkg::OFS_PM_CTRL, 32'hd, 4'h1);
    tick(3);
    chk("pwr", 6'h22, FUNCTION_POWER_STATE);
    apb(1, pcs_pkg::OFS_PM_CTRL, 32'he, 4'h1);
    tick(3);
    chk("pwr", 6'h22, FUNCTION_POWER_STATE);
    $display("test registers done");
    apb(0, 8'h20, 0, 4'hf);
    chk("slverr", 1, er);
    chk("rd_unmap", 0, rd);
    apb(1, pcs_pkg::OFS_STATUS, 32'hffff, 4'hf);
    chk("ro_err", 0, er);
    apb(0, pcs_pkg::OFS_STATUS, 0, 4'hf);
    chk("status", 32'h90d3, rd);
    RST <= 1'b1;
    tick(2);
    chk("down_rst", 0, PHY_LINK_DOWN);
    chk("mrrs_rst", 3'h2, MAX_READ_REQ);
    RST <= 1'b0;
    tick(3);
    chk("down_rel", 0, PHY_LINK_DOWN);
    chk("lstat_rel", 2'h3, PHY_LINK_STATUS);
    chk("mrrs_rel", 3'h2, MAX_READ_REQ);
    $display("test errors done");
    stop_test();
  end
endmodule
